// File: mio_port_set.sv
`timescale 1ns/1ps
`default_nettype none
module mio_port_set
	import mio_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// CPU register access.
	input wire logic [15:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic cpu_rmw_i,
	input wire logic cpu_s1_i,
	input wire logic cpu_s2_i,
	input wire logic [7:0] cpu_wdata_i,
	output logic [7:0] cpu_rdata_o,
	output logic cpu_rvalid_o,
	// One-bit port pins.
	input wire logic [MIO_P1_W-1:0] p1_pin_i,
	output logic [MIO_P1_W-1:0] p1_out_o,
	output logic [MIO_P1_W-1:0] p1_oe_o,
	// Eight-bit port pins.
	input wire logic [MIO_P3_W-1:0] p3_pin_i,
	output logic [MIO_P3_W-1:0] p3_out_o,
	output logic [MIO_P3_W-1:0] p3_oe_o,
	// Six-bit port pins.
	input wire logic [MIO_P4_W-1:0] p4_pin_i,
	output logic [MIO_P4_W-1:0] p4_out_o,
	output logic [MIO_P4_W-1:0] p4_oe_o,
	// Four-bit port pins shared with converter inputs.
	input wire logic [MIO_P6_W-1:0] p6_pin_i,
	output logic [MIO_P6_W-1:0] p6_out_o,
	output logic [MIO_P6_W-1:0] p6_oe_o,
	// Converter hooks.
	output logic [MIO_P6_W-1:0] p6_ana_en_o,
	output logic [MIO_CONV_CH_W-1:0] conv_chan_o,
	output logic conv_start_o
);

	// ==========================================================
	// Register select codes.
	typedef enum logic [3:0] {
		MIO_SEL_NONE = 4'b0000,
		MIO_SEL_P1_LAT = 4'b0001,
		MIO_SEL_P3_LAT = 4'b0010,
		MIO_SEL_P4_LAT = 4'b0011,
		MIO_SEL_P6_LAT = 4'b0100,
		MIO_SEL_P1_DIR = 4'b0101,
		MIO_SEL_CONV_A = 4'b0110,
		MIO_SEL_P3_OD = 4'b0111,
		MIO_SEL_P4_OD = 4'b1000,
		MIO_SEL_P3_DIR = 4'b1001,
		MIO_SEL_P4_DIR = 4'b1010,
		MIO_SEL_P6_DIR = 4'b1011
	} mio_sel_t;

	// ==========================================================
	// Port registers.
	logic [MIO_P1_W-1:0] port1_output_latch_r, port1_output_latch_nxt;
	logic [MIO_P1_W-1:0] port1_direction_r, port1_direction_nxt;
	logic [MIO_P3_W-1:0] port3_output_latch_r, port3_output_latch_nxt;
	logic [MIO_P3_W-1:0] port3_direction_r, port3_direction_nxt;
	logic [MIO_P3_W-1:0] port3_open_drain_select_r;
	logic [MIO_P3_W-1:0] port3_open_drain_select_nxt;
	logic [MIO_P4_W-1:0] port4_output_latch_r, port4_output_latch_nxt;
	logic [MIO_P4_W-1:0] port4_direction_r, port4_direction_nxt;
	logic [MIO_P4_W-1:0] port4_open_drain_select_r;
	logic [MIO_P4_W-1:0] port4_open_drain_select_nxt;
	logic [MIO_P6_W-1:0] port6_output_latch_r, port6_output_latch_nxt;
	logic [MIO_P6_W-1:0] port6_direction_r, port6_direction_nxt;

	// Converter control register.
	logic [7:0] converter_control_a;
	logic analog_input_disable_nxt;
	logic conv_wr;

	// Access strobes.
	logic wr_go;
	logic rd_go;
	logic [7:0] rd_val;
	mio_sel_t sel;

	// Flat views for the pad cells.
	logic [MIO_PIN_N-1:0] all_dir_nxt;
	logic [MIO_PIN_N-1:0] all_lat_nxt;
	logic [MIO_PIN_N-1:0] all_od_nxt;
	logic [MIO_PIN_N-1:0] all_out;
	logic [MIO_PIN_N-1:0] all_oe;

	// ==========================================================
	// Port read view.
	// A read-modify-write sees the latch so that untouched output
	// bits are written back unchanged; any other read sees the pin.
	function automatic logic [7:0] port_view(
		input logic [7:0] lat,
		input logic [7:0] pin,
		input logic rmw
	);
		port_view = rmw ? lat : pin;
	endfunction : port_view

	// ==========================================================
	// Register select.
	// Write and read decode share this one map, so no register can
	// be written at one address and read back at another. Reserved
	// holes and registers of other blocks select nothing.
	function automatic mio_sel_t reg_sel(input logic [15:0] addr);
		reg_sel = MIO_SEL_NONE;
		if (addr == MIO_A_P1_LAT) begin
			reg_sel = MIO_SEL_P1_LAT;
		end else if (addr == MIO_A_P3_LAT) begin
			reg_sel = MIO_SEL_P3_LAT;
		end else if (addr == MIO_A_P4_LAT) begin
			reg_sel = MIO_SEL_P4_LAT;
		end else if (addr == MIO_A_P6_LAT) begin
			reg_sel = MIO_SEL_P6_LAT;
		end else if (addr == MIO_A_P1_DIR) begin
			reg_sel = MIO_SEL_P1_DIR;
		end else if (addr == MIO_A_CONV_A) begin
			reg_sel = MIO_SEL_CONV_A;
		end else if (addr == MIO_A_P3_OD) begin
			reg_sel = MIO_SEL_P3_OD;
		end else if (addr == MIO_A_P4_OD) begin
			reg_sel = MIO_SEL_P4_OD;
		end else if (addr == MIO_A_P3_DIR) begin
			reg_sel = MIO_SEL_P3_DIR;
		end else if (addr == MIO_A_P4_DIR) begin
			reg_sel = MIO_SEL_P4_DIR;
		end else if (addr == MIO_A_P6_DIR) begin
			reg_sel = MIO_SEL_P6_DIR;
		end
	endfunction : reg_sel

	// ==========================================================
	// Access timing.
	// Writes land on S2 of the write cycle, pins are sampled on S1
	// of the read cycle.
	always_comb begin
		wr_go = cpu_wr_i & cpu_s2_i;
		rd_go = cpu_rd_i & cpu_s1_i;
		sel = reg_sel(cpu_addr_i);
		conv_wr = wr_go & (sel == MIO_SEL_CONV_A);
	end

	// ==========================================================
	// Write decode.
	// Only the implemented low bits of narrow ports are kept.
	always_comb begin
		port1_output_latch_nxt = port1_output_latch_r;
		port1_direction_nxt = port1_direction_r;
		port3_output_latch_nxt = port3_output_latch_r;
		port3_direction_nxt = port3_direction_r;
		port3_open_drain_select_nxt = port3_open_drain_select_r;
		port4_output_latch_nxt = port4_output_latch_r;
		port4_direction_nxt = port4_direction_r;
		port4_open_drain_select_nxt = port4_open_drain_select_r;
		port6_output_latch_nxt = port6_output_latch_r;
		port6_direction_nxt = port6_direction_r;
		if (!wr_go) begin
			port1_output_latch_nxt = port1_output_latch_r;
		end else if (sel == MIO_SEL_P1_LAT) begin
			port1_output_latch_nxt = cpu_wdata_i[MIO_P1_W-1:0];
		end else if (sel == MIO_SEL_P3_LAT) begin
			port3_output_latch_nxt = cpu_wdata_i;
		end else if (sel == MIO_SEL_P4_LAT) begin
			port4_output_latch_nxt = cpu_wdata_i[MIO_P4_W-1:0];
		end else if (sel == MIO_SEL_P6_LAT) begin
			port6_output_latch_nxt = cpu_wdata_i[MIO_P6_W-1:0];
		end else if (sel == MIO_SEL_P1_DIR) begin
			port1_direction_nxt = cpu_wdata_i[MIO_P1_W-1:0];
		end else if (sel == MIO_SEL_P3_OD) begin
			port3_open_drain_select_nxt = cpu_wdata_i;
		end else if (sel == MIO_SEL_P4_OD) begin
			port4_open_drain_select_nxt = cpu_wdata_i[MIO_P4_W-1:0];
		end else if (sel == MIO_SEL_P3_DIR) begin
			port3_direction_nxt = cpu_wdata_i;
		end else if (sel == MIO_SEL_P4_DIR) begin
			port4_direction_nxt = cpu_wdata_i[MIO_P4_W-1:0];
		end else if (sel == MIO_SEL_P6_DIR) begin
			port6_direction_nxt = cpu_wdata_i[MIO_P6_W-1:0];
		end
	end

	// ==========================================================
	// One-bit port registers.
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			port1_output_latch_r <= MIO_RST_ZERO[MIO_P1_W-1:0];
			port1_direction_r <= MIO_RST_ZERO[MIO_P1_W-1:0];
		end else begin
			port1_output_latch_r <= port1_output_latch_nxt;
			port1_direction_r <= port1_direction_nxt;
		end
	end

	// ==========================================================
	// Eight-bit port registers.
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			port3_output_latch_r <= MIO_RST_ZERO;
			port3_direction_r <= MIO_RST_ZERO;
			port3_open_drain_select_r <= MIO_RST_ZERO;
		end else begin
			port3_output_latch_r <= port3_output_latch_nxt;
			port3_direction_r <= port3_direction_nxt;
			port3_open_drain_select_r <= port3_open_drain_select_nxt;
		end
	end

	// ==========================================================
	// Six-bit port registers.
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			port4_output_latch_r <= MIO_RST_ZERO[MIO_P4_W-1:0];
			port4_direction_r <= MIO_RST_ZERO[MIO_P4_W-1:0];
			port4_open_drain_select_r <= MIO_RST_ZERO[MIO_P4_W-1:0];
		end else begin
			port4_output_latch_r <= port4_output_latch_nxt;
			port4_direction_r <= port4_direction_nxt;
			port4_open_drain_select_r <= port4_open_drain_select_nxt;
		end
	end

	// ==========================================================
	// Four-bit port registers.
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			port6_output_latch_r <= MIO_RST_ZERO[MIO_P6_W-1:0];
			port6_direction_r <= MIO_RST_ZERO[MIO_P6_W-1:0];
		end else begin
			port6_output_latch_r <= port6_output_latch_nxt;
			port6_direction_r <= port6_direction_nxt;
		end
	end

	// ==========================================================
	// Converter control.
	mio_conv_ctl u_conv (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.wr_i(conv_wr),
		.wdata_i(cpu_wdata_i),
		.reg_o(converter_control_a),
		.dis_nxt_o(analog_input_disable_nxt),
		.chan_o(conv_chan_o),
		.start_o(conv_start_o)
	);

	// An analog switch closes only for an input bit with latch zero
	// and the disable bit clear, so a driven pin never reaches it.
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			p6_ana_en_o <= '0;
		end else begin
			p6_ana_en_o <= ~port6_direction_nxt & ~port6_output_latch_nxt
				& {MIO_P6_W{~analog_input_disable_nxt}};
		end
	end

	// ==========================================================
	// Pad cells.
	// The one-bit and four-bit ports have no open-drain option.
	always_comb begin
		all_dir_nxt = {port6_direction_nxt, port4_direction_nxt,
			port3_direction_nxt, port1_direction_nxt};
		all_lat_nxt = {port6_output_latch_nxt, port4_output_latch_nxt,
			port3_output_latch_nxt, port1_output_latch_nxt};
		all_od_nxt = {{MIO_P6_W{1'b0}}, port4_open_drain_select_nxt,
			port3_open_drain_select_nxt, {MIO_P1_W{1'b0}}};
	end

	genvar gi;
	generate
		for (gi = 0; gi < MIO_PIN_N; gi = gi + 1) begin : g_pad
			mio_pad_bit u_pad (
				.mclk_i(mclk_i),
				.rst_b_i(rst_b_i),
				.dir_nxt_i(all_dir_nxt[gi]),
				.lat_nxt_i(all_lat_nxt[gi]),
				.od_nxt_i(all_od_nxt[gi]),
				.out_o(all_out[gi]),
				.oe_o(all_oe[gi])
			);
		end
	endgenerate

	always_comb begin
		p1_out_o = all_out[0 +: MIO_P1_W];
		p1_oe_o = all_oe[0 +: MIO_P1_W];
		p3_out_o = all_out[MIO_P1_W +: MIO_P3_W];
		p3_oe_o = all_oe[MIO_P1_W +: MIO_P3_W];
		p4_out_o = all_out[MIO_P1_W+MIO_P3_W +: MIO_P4_W];
		p4_oe_o = all_oe[MIO_P1_W+MIO_P3_W +: MIO_P4_W];
		p6_out_o = all_out[MIO_P1_W+MIO_P3_W+MIO_P4_W +: MIO_P6_W];
		p6_oe_o = all_oe[MIO_P1_W+MIO_P3_W+MIO_P4_W +: MIO_P6_W];
	end

	// ==========================================================
	// Read decode.
	// Addresses outside the two areas, reserved holes and registers
	// that belong to other blocks all read as zero.
	always_comb begin
		rd_val = 8'h00;
		if (sel == MIO_SEL_P1_LAT) begin
			rd_val = port_view(8'(port1_output_latch_r),
				8'(p1_pin_i), cpu_rmw_i);
		end else if (sel == MIO_SEL_P3_LAT) begin
			rd_val = port_view(port3_output_latch_r, p3_pin_i,
				cpu_rmw_i);
		end else if (sel == MIO_SEL_P4_LAT) begin
			rd_val = port_view(8'(port4_output_latch_r),
				8'(p4_pin_i), cpu_rmw_i);
		end else if (sel == MIO_SEL_P6_LAT) begin
			// A bit whose latch is zero reads zero whatever the pin
			// shows, even when a driven pin is being fought.
			rd_val = port_view(8'(port6_output_latch_r),
				8'(p6_pin_i & port6_output_latch_r),
				cpu_rmw_i);
		end else if (sel == MIO_SEL_P1_DIR) begin
			rd_val = 8'(port1_direction_r);
		end else if (sel == MIO_SEL_CONV_A) begin
			rd_val = converter_control_a;
		end else if (sel == MIO_SEL_P3_OD) begin
			rd_val = port3_open_drain_select_r;
		end else if (sel == MIO_SEL_P4_OD) begin
			rd_val = 8'(port4_open_drain_select_r);
		end else if (sel == MIO_SEL_P3_DIR) begin
			rd_val = port3_direction_r;
		end else if (sel == MIO_SEL_P4_DIR) begin
			rd_val = 8'(port4_direction_r);
		end else if (sel == MIO_SEL_P6_DIR) begin
			rd_val = 8'(port6_direction_r);
		end
	end

	// ==========================================================
	// Read data register.
	// Pins have no input latch, so the value seen is whatever the
	// pin holds at S1; noisy inputs must be filtered by software.
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			cpu_rdata_o <= 8'h00;
			cpu_rvalid_o <= 1'b0;
		end else begin
			cpu_rvalid_o <= rd_go;
			if (rd_go) begin
				cpu_rdata_o <= rd_val;
			end
		end
	end

endmodule : mio_port_set
`default_nettype wire

// File: mio_pkg.sv
// How it works
// - Outputs hold latch value; inputs read pins directly
// - Pin levels sampled on S1 of reads
// - Written data reaches latch on S2
// - Read-modify-write reads latch, others read pins
// - One-bit port direction and latch reset zero
// - Eight-bit port direction and latch reset zero
// - Eight-bit port per-bit open-drain, reset tri-state
// - Six-bit port direction and latch reset zero
// - Six-bit port per-bit open-drain, reset tri-state
// - Open-drain bit: RMW reads latch, else pin
// - Four-bit port resets zero, converter inputs disabled
// - Four-bit direction one drives pin from latch
// - Clearing input-disable bit starts analog conversion
// - Converter field selects analog channel independently
// - Four-bit bit with latch zero reads zero
// - Registers mapped in special-function and buffer areas
package mio_pkg;

	// ==========================================================
	// Address map.
	localparam logic [15:0] MIO_SFA_LO = 16'h0000;
	localparam logic [15:0] MIO_SFA_HI = 16'h003F;
	localparam logic [15:0] MIO_DBA_LO = 16'h1F80;
	localparam logic [15:0] MIO_DBA_HI = 16'h1FFF;
	localparam logic [15:0] MIO_A_P1_LAT = 16'h0001;
	localparam logic [15:0] MIO_A_P3_LAT = 16'h0003;
	localparam logic [15:0] MIO_A_P4_LAT = 16'h0004;
	localparam logic [15:0] MIO_A_P6_LAT = 16'h0006;
	localparam logic [15:0] MIO_A_P1_DIR = 16'h000B;
	localparam logic [15:0] MIO_A_CONV_A = 16'h0026;
	localparam logic [15:0] MIO_A_P3_OD = 16'h1F83;
	localparam logic [15:0] MIO_A_P4_OD = 16'h1F84;
	localparam logic [15:0] MIO_A_P3_DIR = 16'h1F89;
	localparam logic [15:0] MIO_A_P4_DIR = 16'h1F8A;
	localparam logic [15:0] MIO_A_P6_DIR = 16'h1F8C;

	// ==========================================================
	// Port widths.
	localparam int MIO_P1_W = 1;
	localparam int MIO_P3_W = 8;
	localparam int MIO_P4_W = 6;
	localparam int MIO_P6_W = 4;
	localparam int MIO_PIN_N = 19;

	// ==========================================================
	// Reset values.
	localparam logic [7:0] MIO_RST_ZERO = 8'h00;
	localparam logic [7:0] MIO_RST_CONV_A = 8'h20;

	// ==========================================================
	// Converter control field layout.
	localparam int MIO_CONV_DIS_BIT = 5;
	localparam int MIO_CONV_CH_LSB = 0;
	localparam int MIO_CONV_CH_W = 2;

endpackage : mio_pkg

// File: mio_pad_bit.sv
`timescale 1ns/1ps
`default_nettype none
module mio_pad_bit
	import mio_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Next register values for this bit.
	input wire logic dir_nxt_i,
	input wire logic lat_nxt_i,
	input wire logic od_nxt_i,
	// Pin drive.
	output logic out_o,
	output logic oe_o
);

	// ==========================================================
	// Drive flops follow the register next values so the pin
	// changes on the same edge as the latch.
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			out_o <= 1'b0;
			oe_o <= 1'b0;
		end else if (od_nxt_i) begin
			// Open-drain only ever pulls low.
			out_o <= 1'b0;
			oe_o <= dir_nxt_i & ~lat_nxt_i;
		end else begin
			out_o <= lat_nxt_i;
			oe_o <= dir_nxt_i;
		end
	end

endmodule : mio_pad_bit
`default_nettype wire

// File: mio_conv_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module mio_conv_ctl
	import mio_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Write strobe and data.
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	// Register state.
	output logic [7:0] reg_o,
	output logic dis_nxt_o,
	output logic [MIO_CONV_CH_W-1:0] chan_o,
	output logic start_o
);

	logic [7:0] reg_nxt;

	// ==========================================================
	// Control register.
	always_comb begin
		reg_nxt = wr_i ? wdata_i : reg_o;
		dis_nxt_o = reg_nxt[MIO_CONV_DIS_BIT];
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			reg_o <= MIO_RST_CONV_A;
		end else begin
			reg_o <= reg_nxt;
		end
	end

	// ==========================================================
	// Channel select and start pulse.
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			chan_o <= '0;
			start_o <= 1'b0;
		end else begin
			chan_o <= reg_nxt[MIO_CONV_CH_LSB +: MIO_CONV_CH_W];
			start_o <= wr_i & ~wdata_i[MIO_CONV_DIS_BIT];
		end
	end

endmodule : mio_conv_ctl
`default_nettype wire

// File: mio_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Board side of one port.
module mio_board_model #(
	parameter int W = 8
) (
	// Device drive.
	input wire logic [W-1:0] out_i,
	input wire logic [W-1:0] oe_i,
	// Board drivers.
	input wire logic [W-1:0] val_i,
	input wire logic [W-1:0] en_i,
	// Resolved pin level.
	output logic [W-1:0] pin_o
);
	// Undriven lines float up through the board pull-ups, never to a stale value.
	assign pin_o = (oe_i & out_i) | (~oe_i & ((en_i & val_i) | ~en_i));
endmodule : mio_board_model
`default_nettype wire

// File: mio_port_set_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mio_port_set_properties
	import mio_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// CPU register access.
	input wire logic [15:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic cpu_rmw_i,
	input wire logic cpu_s1_i,
	input wire logic cpu_s2_i,
	input wire logic [7:0] cpu_wdata_i,
	input wire logic [7:0] cpu_rdata_o,
	input wire logic cpu_rvalid_o,
	// Port pins.
	input wire logic [MIO_P1_W-1:0] p1_pin_i,
	input wire logic [MIO_P1_W-1:0] p1_out_o,
	input wire logic [MIO_P1_W-1:0] p1_oe_o,
	input wire logic [MIO_P3_W-1:0] p3_pin_i,
	input wire logic [MIO_P3_W-1:0] p3_out_o,
	input wire logic [MIO_P3_W-1:0] p3_oe_o,
	input wire logic [MIO_P4_W-1:0] p4_pin_i,
	input wire logic [MIO_P4_W-1:0] p4_out_o,
	input wire logic [MIO_P4_W-1:0] p4_oe_o,
	input wire logic [MIO_P6_W-1:0] p6_pin_i,
	input wire logic [MIO_P6_W-1:0] p6_out_o,
	input wire logic [MIO_P6_W-1:0] p6_oe_o,
	// Converter hooks.
	input wire logic [MIO_P6_W-1:0] p6_ana_en_o,
	input wire logic [MIO_CONV_CH_W-1:0] conv_chan_o,
	input wire logic conv_start_o
);
	// ====================
	// Helpers.
	logic rd_s;
	logic wr_s;
	logic cw0;
	logic [1:0] wd_ch;
	assign rd_s = cpu_rd_i & cpu_s1_i;
	assign wr_s = cpu_wr_i & cpu_s2_i;
	assign cw0 = wr_s && cpu_addr_i == MIO_A_CONV_A && !cpu_wdata_i[5];
	assign wd_ch = cpu_wdata_i[1:0];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_go;
		cw0;
	endsequence
	sequence s_p1rd;
		rd_s && !cpu_rmw_i && cpu_addr_i == MIO_A_P1_LAT;
	endsequence
	// ====================
	// Properties.
	property p_rv;
		rd_s |=> cpu_rvalid_o;
	endproperty
	property p_rv_cause;
		cpu_rvalid_o |-> $past(rd_s);
	endproperty
	property p_hold;
		!rd_s |=> $stable(cpu_rdata_o);
	endproperty
	property p_p1pin;
		s_p1rd |=> cpu_rdata_o == {7'h00, $past(p1_pin_i)};
	endproperty
	property p_p6rd;
		rd_s && !cpu_rmw_i && cpu_addr_i == MIO_A_P6_LAT |=>
			cpu_rdata_o[7:4] == 4'h0 && (cpu_rdata_o[3:0] & ~$past(p6_pin_i)) == 4'h0;
	endproperty
	property p_p3wr;
		wr_s && cpu_addr_i == MIO_A_P3_LAT |=>
			((p3_out_o ^ $past(cpu_wdata_i)) & p3_oe_o) == 8'h00;
	endproperty
	property p_start;
		s_go |=> conv_start_o;
	endproperty
	property p_start_cause;
		conv_start_o |-> $past(cw0);
	endproperty
	property p_chan;
		wr_s && cpu_addr_i == MIO_A_CONV_A |=> conv_chan_o == $past(wd_ch);
	endproperty
	property p_excl;
		(p6_ana_en_o & p6_oe_o) == 4'h0;
	endproperty
	property p_rst;
		disable iff (1'b0) !rst_b_i |=> !(|{p1_oe_o, p3_oe_o, p4_oe_o, p6_oe_o,
			p6_ana_en_o, conv_start_o, cpu_rvalid_o});
	endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	a_rv_cause: assert property (p_rv_cause) else $error("stray answer");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_p1pin: assert property (p_p1pin) else $error("pin read wrong");
	a_p6rd: assert property (p_p6rd) else $error("narrow read wrong");
	a_p3wr: assert property (p_p3wr) else $error("latch drive wrong");
	a_start: assert property (p_start) else $error("no start");
	a_start_cause: assert property (p_start_cause) else $error("bad start");
	a_chan: assert property (p_chan) else $error("channel wrong");
	a_excl: assert property (p_excl) else $error("analog and drive");
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : mio_port_set_properties
bind mio_port_set mio_port_set_properties u_chk (.*);
`default_nettype wire

// File: mio_port_set_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("ERROR %s expected %h seen %h", n, e, g); \
	end \
end
module mio_port_set_tb
	import mio_pkg::*;
;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cpu_rd_i = 1'b0;
	logic cpu_wr_i = 1'b0;
	logic cpu_rmw_i = 1'b0;
	logic cpu_s1_i = 1'b0;
	logic cpu_s2_i = 1'b0;
	logic [15:0] cpu_addr_i = 16'h0000;
	logic [7:0] cpu_wdata_i = 8'h00;
	logic [7:0] cpu_rdata_o;
	logic cpu_rvalid_o, conv_start_o;
	logic [MIO_P1_W-1:0] p1_pin_i, p1_out_o, p1_oe_o;
	logic [MIO_P3_W-1:0] p3_pin_i, p3_out_o, p3_oe_o;
	logic [MIO_P4_W-1:0] p4_pin_i, p4_out_o, p4_oe_o;
	logic [MIO_P6_W-1:0] p6_pin_i, p6_out_o, p6_oe_o, p6_ana_en_o;
	logic [MIO_CONV_CH_W-1:0] conv_chan_o;
	logic [7:0] ev [4] = '{default: 8'h00};
	logic [7:0] ee [4] = '{default: 8'h00};
	logic [7:0] q [$];
	logic [7:0] exp_r;
	integer err_total = 0;
	integer samples_checked = 0;
	integer seed = 95462;
	integer starts = 0;
	localparam logic [15:0] LA [4] = '{MIO_A_P1_LAT, MIO_A_P3_LAT,
		MIO_A_P4_LAT, MIO_A_P6_LAT};
	localparam logic [15:0] DA [4] = '{MIO_A_P1_DIR, MIO_A_P3_DIR,
		MIO_A_P4_DIR, MIO_A_P6_DIR};
	localparam logic [15:0] OA [4] = '{16'h0000, MIO_A_P3_OD, MIO_A_P4_OD,
		16'h0000};
	localparam logic [7:0] MK [4] = '{8'h01, 8'hFF, 8'h3F, 8'h0F};

	mio_port_set DUT (.*);
	mio_board_model #(.W(1)) u_b1 (.out_i(p1_out_o), .oe_i(p1_oe_o),
		.val_i(ev[0][0:0]), .en_i(ee[0][0:0]), .pin_o(p1_pin_i));
	mio_board_model #(.W(8)) u_b3 (.out_i(p3_out_o), .oe_i(p3_oe_o),
		.val_i(ev[1]), .en_i(ee[1]), .pin_o(p3_pin_i));
	mio_board_model #(.W(6)) u_b4 (.out_i(p4_out_o), .oe_i(p4_oe_o),
		.val_i(ev[2][5:0]), .en_i(ee[2][5:0]), .pin_o(p4_pin_i));
	mio_board_model #(.W(4)) u_b6 (.out_i(p6_out_o), .oe_i(p6_oe_o),
		.val_i(ev[3][3:0]), .en_i(ee[3][3:0]), .pin_o(p6_pin_i));

	// ====================
	// Bus tasks and result watcher.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		cpu_addr_i <= a;
		cpu_wdata_i <= d;
		cpu_wr_i <= 1'b1;
		cpu_s2_i <= 1'b1;
		@(posedge mclk_i);
		cpu_wr_i <= 1'b0;
		cpu_s2_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic m, input logic [7:0] e);
		@(posedge mclk_i);
		cpu_addr_i <= a;
		cpu_rmw_i <= m;
		cpu_rd_i <= 1'b1;
		cpu_s1_i <= 1'b1;
		q.push_back(e);
		@(posedge mclk_i);
		cpu_rd_i <= 1'b0;
		cpu_s1_i <= 1'b0;
	endtask : rd

	function automatic logic [15:0] pads(input int p);
		case (p)
			0: return {7'h00, p1_oe_o, 7'h00, p1_out_o};
			1: return {p3_oe_o, p3_out_o};
			2: return {2'h0, p4_oe_o, 2'h0, p4_out_o};
			default: return {4'h0, p6_oe_o, 4'h0, p6_out_o};
		endcase
	endfunction : pads

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	always @(posedge mclk_i) begin
		if (cpu_rvalid_o === 1'b1) begin
			exp_r = q.pop_front();
			`CHK("rdata", exp_r, cpu_rdata_o)
		end
		if (conv_start_o === 1'b1) begin
			starts++;
		end
	end

	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end

	initial begin
		#200000;
		err_total++;
		end_sim();
	end

	// ====================
	// Main sequence.
	initial begin
		int p;
		int s0;
		logic [7:0] d, l, o, dm, lm, om, oe, pin, c, ana;
		logic [15:0] g;
		repeat (6) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(LA[i], 1'b1, 8'h00);
			rd(DA[i], 1'b0, 8'h00);
		end
		rd(MIO_A_P3_OD, 1'b0, 8'h00);
		rd(MIO_A_P4_OD, 1'b0, 8'h00);
		rd(MIO_A_CONV_A, 1'b0, MIO_RST_CONV_A);
		wr(16'h0002, 8'hA5);
		rd(16'h0002, 1'b0, 8'h00);
		rd(16'h1FCC, 1'b0, 8'h00);
		for (int n = 0; n < 24; n++) begin
			p = n % 4;
			d = 8'($random(seed));
			l = 8'($random(seed));
			o = (OA[p] != 16'h0000) ? 8'($random(seed)) : 8'h00;
			ev[p] <= 8'($random(seed));
			ee[p] <= 8'($random(seed));
			wr(DA[p], d);
			wr(LA[p], l);
			if (OA[p] != 16'h0000) begin
				wr(OA[p], o);
			end
			dm = d & MK[p];
			lm = l & MK[p];
			om = o & MK[p];
			oe = dm & ~(om & lm);
			pin = ((oe & lm) | (~oe & ((ee[p] & ev[p]) | ~ee[p]))) & MK[p];
			pin = (p == 3) ? pin & lm : pin;
			rd(DA[p], 1'b0, dm);
			rd(LA[p], 1'b1, lm);
			rd(LA[p], 1'b0, pin);
			#1;
			g = pads(p);
			`CHK("oe", oe, g[15:8])
			`CHK("out", lm & oe, g[7:0] & oe)
			if (p == 3) begin
				s0 = starts;
				c = 8'($random(seed));
				c[5] = n[2];
				wr(MIO_A_CONV_A, c);
				rd(MIO_A_CONV_A, 1'b0, c);
				#1;
				ana = ~dm & ~lm & ~{8{c[5]}} & 8'h0F;
				`CHK("starts", s0 + (c[5] ? 0 : 1), starts)
				`CHK("chan", c[1:0], conv_chan_o)
				`CHK("ana", ana[3:0], p6_ana_en_o)
			end
		end
		// Four-bit digital input, then a motor-ready eight-bit latch.
		ee[3] <= 8'h0F;
		ev[3] <= 8'($random(seed));
		wr(MIO_A_P6_DIR, 8'h00);
		wr(MIO_A_P6_LAT, 8'h0F);
		rd(MIO_A_P6_LAT, 1'b0, ev[3] & 8'h0F);
		wr(MIO_A_CONV_A, 8'h00);
		#1;
		`CHK("ana", 4'h0, p6_ana_en_o)
		wr(MIO_A_P3_LAT, 8'hFF);
		rd(MIO_A_P3_LAT, 1'b1, 8'hFF);
		repeat (4) @(posedge mclk_i);
		`CHK("pending", 0, q.size())
		end_sim();
	end
endmodule : mio_port_set_tb
`default_nettype wire
